// ===== inc/tpc_pkg.sv
// timer pin i/o control constants for channels 0 to 2
// assumes one 100 MHz clock and a plain strobe register port
// What this block does
// - code 0xxx is compare; bit 2 initial level; 01 drives low on match
// - compare code x10 starts at initial level, drives high on match
// - compare code x11 toggles on match; code x00 leaves pin disabled
// - code 1000 captures on rising edge; channel 2 ignores bit 2
// - code 1001 captures on falling pin edge
// - code 101x captures on both pin edges
// - channel 0 C code 11xx captures on each channel 1 count
// - channel 1 A code 11xx captures on channel 0 A match
// - channel 0 buffer bit set blocks C capture and compare
package tpc_pkg;

  // --------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned CTL_W  = 8;

  // --------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CH0_C_CTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CH1_CTL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CH2_CTL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CH0_MODE  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RUN       = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CH0_GRA   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CH0_GRC   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CH1_GRA   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CH2_GRA   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CNT0      = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CNT1      = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_CNT2      = 8'h2C;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int unsigned POS_SEL_MODE = 3;
  localparam int unsigned POS_SEL_INIT = 2;
  localparam int unsigned POS_BUF_OP_A = 4;
  localparam int unsigned POS_RUN0     = 0;
  localparam int unsigned POS_RUN1     = 1;
  localparam int unsigned POS_RUN2     = 2;
  localparam int unsigned POS_CH1_DOWN = 3;

  // --------------------------------------------------------------------
  // compare actions in bits 1:0
  // --------------------------------------------------------------------
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [CTL_W-1:0] RST_CTL  = 8'h00;
  localparam logic [CTL_W-1:0] RST_MODE = 8'h00;
  localparam logic [CTL_W-1:0] RST_RUN  = 8'h00;
  localparam logic [CNT_W-1:0] RST_GR   = 16'hFFFF;
  localparam logic [CNT_W-1:0] RST_CNT  = 16'h0000;

endpackage : tpc_pkg

// ===== logic/tpc_chan.sv
// compare output and capture decision for one general register
// assumes edges and match are one-cycle pulses on clk_in
`timescale 1ns/1ns
module tpc_chan
  import tpc_pkg::*;
#(
  parameter bit HAS_CASCADE = 1'b1
)(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic [3:0] sel_in,
  input  wire logic       sel_wr_in,
  input  wire logic       block_in,
  input  wire logic       match_in,
  input  wire logic       rise_in,
  input  wire logic       fall_in,
  input  wire logic       cascade_in,
  output logic            capture_out,
  output logic            pin_out,
  output logic            oe_out
);

  logic       cmp_mode;
  logic [1:0] act;
  logic       ev;
  logic       pin_q;
  logic       oe_q;
  logic       sel_wr_q;

  assign cmp_mode = ~sel_in[POS_SEL_MODE];
  assign act      = sel_in[1:0];

  // --------------------------------------------------------------------
  // capture source select
  // --------------------------------------------------------------------
  always_comb begin
    if (HAS_CASCADE && sel_in[POS_SEL_INIT]) begin
      ev = cascade_in;
    end else if (sel_in[1]) begin
      ev = rise_in | fall_in;
    end else if (sel_in[0]) begin
      ev = fall_in;
    end else begin
      ev = rise_in;
    end
  end

  assign capture_out = ce_in & ~cmp_mode & ~block_in & ev;

  // write strobe delayed until the new code sits in sel_in
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_wr_q <= 1'b0;
    end else if (ce_in) begin
      sel_wr_q <= sel_wr_in;
    end
  end

  // --------------------------------------------------------------------
  // compare output pin
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= 1'b0;
    end else if (ce_in) begin
      if (sel_wr_q && cmp_mode) begin
        pin_q <= sel_in[POS_SEL_INIT];
      end else if (cmp_mode && match_in && !block_in) begin
        case (act)
          ACT_LOW:    pin_q <= 1'b0;
          ACT_HIGH:   pin_q <= 1'b1;
          ACT_TOGGLE: pin_q <= ~pin_q;
          default:    pin_q <= pin_q;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_q <= 1'b0;
    end else if (ce_in) begin
      oe_q <= cmp_mode && (act != ACT_OFF) && !block_in;
    end
  end

  assign pin_out = pin_q;
  assign oe_out  = oe_q;

endmodule : tpc_chan

// ===== logic/tpc_pin_sync.sv
// two-stage synchroniser with edge pulses for one timer pin
// assumes the pin is asynchronous to clk_in
`timescale 1ns/1ns
module tpc_pin_sync
  import tpc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // --------------------------------------------------------------------
  // synchroniser and history
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (ce_in) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_out = ce_in & sync_q & ~last_q;
  assign fall_out = ce_in & ~sync_q & last_q;

endmodule : tpc_pin_sync

// ===== logic/tpc_top.sv
// pin i/o control for timer channels 0 to 2 with counters and registers
// assumes a plain strobe register port; pins are asynchronous inputs
`timescale 1ns/1ns
module tpc_top
  import tpc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  input  wire logic              ch0_pin_c_in,
  output logic                   ch0_pin_c_out,
  output logic                   ch0_pin_c_oe_out,
  input  wire logic              ch1_pin_a_in,
  output logic                   ch1_pin_a_out,
  output logic                   ch1_pin_a_oe_out,
  input  wire logic              ch2_pin_a_in,
  output logic                   ch2_pin_a_out,
  output logic                   ch2_pin_a_oe_out
);

  // --------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------
  logic [CTL_W-1:0]  ch0_c_pin_io_control_q;
  logic [CTL_W-1:0]  ch1_pin_io_control_q;
  logic [CTL_W-1:0]  ch2_pin_io_control_q;
  logic [CTL_W-1:0]  ch0_mode_reg_q;
  logic [CTL_W-1:0]  run_ctl_q;
  logic [CNT_W-1:0]  ch0_general_reg_a_q;
  logic [CNT_W-1:0]  ch0_general_reg_c_q;
  logic [CNT_W-1:0]  ch1_general_reg_a_q;
  logic [CNT_W-1:0]  ch2_general_reg_a_q;
  logic [CNT_W-1:0]  cnt0_q;
  logic [CNT_W-1:0]  cnt1_q;
  logic [CNT_W-1:0]  cnt2_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // --------------------------------------------------------------------
  // decoded strobes and events
  // --------------------------------------------------------------------
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_ctl2;
  logic tick0;
  logic tick1;
  logic tick2;
  logic buf_on;
  logic match0_a;
  logic match0_c;
  logic match1_a;
  logic match2_a;
  logic cap0_c;
  logic cap1_a;
  logic cap2_a;
  logic rise0;
  logic fall0;
  logic rise1;
  logic fall1;
  logic rise2;
  logic fall2;
  logic pin0_q;
  logic pin1_q;
  logic pin2_q;
  logic oe0_q;
  logic oe1_q;
  logic oe2_q;

  assign wr_ctl0 = ce_in && wr_in && (addr_in == OFS_CH0_C_CTL);
  assign wr_ctl1 = ce_in && wr_in && (addr_in == OFS_CH1_CTL);
  assign wr_ctl2 = ce_in && wr_in && (addr_in == OFS_CH2_CTL);

  assign tick0  = ce_in & run_ctl_q[POS_RUN0];
  assign tick1  = ce_in & run_ctl_q[POS_RUN1];
  assign tick2  = ce_in & run_ctl_q[POS_RUN2];
  assign buf_on = ch0_mode_reg_q[POS_BUF_OP_A];

  // a match is the count that reaches the register value
  assign match0_a = tick0 && (cnt0_q == ch0_general_reg_a_q);
  assign match0_c = tick0 && (cnt0_q == ch0_general_reg_c_q);
  assign match1_a = tick1 && (cnt1_q == ch1_general_reg_a_q);
  assign match2_a = tick2 && (cnt2_q == ch2_general_reg_a_q);

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  tpc_pin_sync u_sync0 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .pin_in   (ch0_pin_c_in),
    .rise_out (rise0),
    .fall_out (fall0)
  );

  tpc_pin_sync u_sync1 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .pin_in   (ch1_pin_a_in),
    .rise_out (rise1),
    .fall_out (fall1)
  );

  tpc_pin_sync u_sync2 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .pin_in   (ch2_pin_a_in),
    .rise_out (rise2),
    .fall_out (fall2)
  );

  // --------------------------------------------------------------------
  // channel pin functions
  // --------------------------------------------------------------------
  tpc_chan #(.HAS_CASCADE(1'b1)) u_ch0_c (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .sel_in      (ch0_c_pin_io_control_q[3:0]),
    .sel_wr_in   (wr_ctl0),
    .block_in    (buf_on),
    .match_in    (match0_c),
    .rise_in     (rise0),
    .fall_in     (fall0),
    .cascade_in  (tick1),
    .capture_out (cap0_c),
    .pin_out     (pin0_q),
    .oe_out      (oe0_q)
  );

  tpc_chan #(.HAS_CASCADE(1'b1)) u_ch1_a (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .sel_in      (ch1_pin_io_control_q[3:0]),
    .sel_wr_in   (wr_ctl1),
    .block_in    (1'b0),
    .match_in    (match1_a),
    .rise_in     (rise1),
    .fall_in     (fall1),
    .cascade_in  (match0_a),
    .capture_out (cap1_a),
    .pin_out     (pin1_q),
    .oe_out      (oe1_q)
  );

  tpc_chan #(.HAS_CASCADE(1'b0)) u_ch2_a (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .sel_in      (ch2_pin_io_control_q[3:0]),
    .sel_wr_in   (wr_ctl2),
    .block_in    (1'b0),
    .match_in    (match2_a),
    .rise_in     (rise2),
    .fall_in     (fall2),
    .cascade_in  (1'b0),
    .capture_out (cap2_a),
    .pin_out     (pin2_q),
    .oe_out      (oe2_q)
  );

  // --------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch0_c_pin_io_control_q <= RST_CTL;
      ch1_pin_io_control_q   <= RST_CTL;
      ch2_pin_io_control_q   <= RST_CTL;
      ch0_mode_reg_q         <= RST_MODE;
      run_ctl_q              <= RST_RUN;
    end else if (ce_in && wr_in) begin
      if (addr_in == OFS_CH0_C_CTL) begin
        ch0_c_pin_io_control_q <= wdata_in[CTL_W-1:0];
      end else if (addr_in == OFS_CH1_CTL) begin
        ch1_pin_io_control_q <= wdata_in[CTL_W-1:0];
      end else if (addr_in == OFS_CH2_CTL) begin
        ch2_pin_io_control_q <= wdata_in[CTL_W-1:0];
      end else if (addr_in == OFS_CH0_MODE) begin
        ch0_mode_reg_q <= wdata_in[CTL_W-1:0];
      end else if (addr_in == OFS_RUN) begin
        run_ctl_q <= wdata_in[CTL_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // counters
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt0_q <= RST_CNT;
      cnt1_q <= RST_CNT;
      cnt2_q <= RST_CNT;
    end else if (ce_in) begin
      if (wr_in && addr_in == OFS_CNT0) begin
        cnt0_q <= wdata_in[CNT_W-1:0];
      end else if (tick0) begin
        cnt0_q <= cnt0_q + 16'h0001;
      end
      if (wr_in && addr_in == OFS_CNT1) begin
        cnt1_q <= wdata_in[CNT_W-1:0];
      end else if (tick1 && run_ctl_q[POS_CH1_DOWN]) begin
        cnt1_q <= cnt1_q - 16'h0001;
      end else if (tick1) begin
        cnt1_q <= cnt1_q + 16'h0001;
      end
      if (wr_in && addr_in == OFS_CNT2) begin
        cnt2_q <= wdata_in[CNT_W-1:0];
      end else if (tick2) begin
        cnt2_q <= cnt2_q + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // general registers: capture beats a software write
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch0_general_reg_a_q <= RST_GR;
    end else if (ce_in) begin
      if (buf_on && match0_a) begin
        ch0_general_reg_a_q <= ch0_general_reg_c_q;
      end else if (wr_in && addr_in == OFS_CH0_GRA) begin
        ch0_general_reg_a_q <= wdata_in[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch0_general_reg_c_q <= RST_GR;
    end else if (ce_in) begin
      if (cap0_c) begin
        ch0_general_reg_c_q <= cnt0_q;
      end else if (wr_in && addr_in == OFS_CH0_GRC) begin
        ch0_general_reg_c_q <= wdata_in[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch1_general_reg_a_q <= RST_GR;
    end else if (ce_in) begin
      if (cap1_a) begin
        ch1_general_reg_a_q <= cnt1_q;
      end else if (wr_in && addr_in == OFS_CH1_GRA) begin
        ch1_general_reg_a_q <= wdata_in[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch2_general_reg_a_q <= RST_GR;
    end else if (ce_in) begin
      if (cap2_a) begin
        ch2_general_reg_a_q <= cnt2_q;
      end else if (wr_in && addr_in == OFS_CH2_GRA) begin
        ch2_general_reg_a_q <= wdata_in[CNT_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (addr_in == OFS_CH0_C_CTL) begin
      rdata_d[CTL_W-1:0] = ch0_c_pin_io_control_q;
    end else if (addr_in == OFS_CH1_CTL) begin
      rdata_d[CTL_W-1:0] = ch1_pin_io_control_q;
    end else if (addr_in == OFS_CH2_CTL) begin
      rdata_d[CTL_W-1:0] = ch2_pin_io_control_q;
    end else if (addr_in == OFS_CH0_MODE) begin
      rdata_d[CTL_W-1:0] = ch0_mode_reg_q;
    end else if (addr_in == OFS_RUN) begin
      rdata_d[CTL_W-1:0] = run_ctl_q;
    end else if (addr_in == OFS_CH0_GRA) begin
      rdata_d[CNT_W-1:0] = ch0_general_reg_a_q;
    end else if (addr_in == OFS_CH0_GRC) begin
      rdata_d[CNT_W-1:0] = ch0_general_reg_c_q;
    end else if (addr_in == OFS_CH1_GRA) begin
      rdata_d[CNT_W-1:0] = ch1_general_reg_a_q;
    end else if (addr_in == OFS_CH2_GRA) begin
      rdata_d[CNT_W-1:0] = ch2_general_reg_a_q;
    end else if (addr_in == OFS_CNT0) begin
      rdata_d[CNT_W-1:0] = cnt0_q;
    end else if (addr_in == OFS_CNT1) begin
      rdata_d[CNT_W-1:0] = cnt1_q;
    end else if (addr_in == OFS_CNT2) begin
      rdata_d[CNT_W-1:0] = cnt2_q;
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= '0;
    end else if (ce_in) begin
      rdata_q <= rd_in ? rdata_d : '0;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign rdata_out        = rdata_q;
  assign ch0_pin_c_out    = pin0_q;
  assign ch0_pin_c_oe_out = oe0_q;
  assign ch1_pin_a_out    = pin1_q;
  assign ch1_pin_a_oe_out = oe1_q;
  assign ch2_pin_a_out    = pin2_q;
  assign ch2_pin_a_oe_out = oe2_q;

endmodule : tpc_top

// ===== tb/timer_pin_io_control_ch0_2_tb_top.sv
// self-checking bench for the timer pin i/o control top
// assumes tpc_top, tpc_pin_model and tpc_monitor are compiled first
`timescale 1ns/1ns
module timer_pin_io_control_ch0_2_tb_top;
  import tpc_pkg::*;
  logic              clk_in   = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              ce_in    = 1'b1;
  logic [ADDR_W-1:0] addr_in  = 8'h00;
  logic [DATA_W-1:0] wdata_in = 32'h0;
  logic              wr_in    = 1'b0;
  logic              rd_in    = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic [2:0]        lvl      = 3'h0;
  logic [2:0]        pin, pout, poe;
  int                n_errors = 0;
  int                samples_checked = 0;
  logic [3:0]        c;
  always #5 clk_in = ~clk_in;
  tpc_top tpc_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ch0_pin_c_in(pin[0]), .ch0_pin_c_out(pout[0]),
    .ch0_pin_c_oe_out(poe[0]), .ch1_pin_a_in(pin[1]),
    .ch1_pin_a_out(pout[1]), .ch1_pin_a_oe_out(poe[1]),
    .ch2_pin_a_in(pin[2]), .ch2_pin_a_out(pout[2]),
    .ch2_pin_a_oe_out(poe[2]));
  tpc_pin_model tpc_pin_model_inst (.lvl_in(lvl), .out_in(pout),
    .oe_in(poe), .pin_out(pin));
  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata_out, exp);
  endtask : rchk
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rchk(8'(i * 4), (i >= 5 && i <= 8) ? 32'hFFFF : 32'h0);
    end
    wr(8'h30, 32'hFF);
    rchk(8'h30, 32'h0);
    // every compare code on ch1, one match each
    for (int k = 0; k < 8; k++) begin
      c = 4'(k);
      wr(OFS_CH1_GRA, 32'h5);
      wr(OFS_CNT1, 32'h0);
      wr(OFS_CH1_CTL, {28'h0, c});
      @(posedge clk_in);
      #1 chk("ch1 oe", poe[1], c[1:0] != ACT_OFF);
      if (c[1:0] != ACT_OFF) chk("ch1 init", pout[1], c[2]);
      wr(OFS_RUN, 32'h2);
      repeat (8) @(posedge clk_in);
      wr(OFS_RUN, 32'h0);
      case (c[1:0])
        ACT_LOW:    chk("ch1 low", pout[1], 1'b0);
        ACT_HIGH:   chk("ch1 high", pout[1], 1'b1);
        ACT_TOGGLE: chk("ch1 toggle", pout[1], !c[2]);
        default:    chk("ch1 off", poe[1], 1'b0);
      endcase
    end
    // every capture code on ch2, rising then falling edge
    for (int k = 8; k < 16; k++) begin
      c = 4'(k);
      wr(OFS_CH2_CTL, {28'h0, c});
      wr(OFS_CNT2, 32'h100 + k);
      wr(OFS_CH2_GRA, 32'hFFFF);
      lvl[2] <= 1'b1;
      repeat (6) @(posedge clk_in);
      rchk(OFS_CH2_GRA, (c[1] | !c[0]) ? 32'h100 + k : 32'hFFFF);
      wr(OFS_CH2_GRA, 32'hFFFF);
      lvl[2] <= 1'b0;
      repeat (6) @(posedge clk_in);
      rchk(OFS_CH2_GRA, (c[1] | c[0]) ? 32'h100 + k : 32'hFFFF);
    end
    // ch0 c capture, then blocked by buffer operation
    wr(OFS_CNT0, 32'hA5A);
    wr(OFS_CH0_C_CTL, 32'hA);
    lvl[0] <= 1'b1;
    repeat (6) @(posedge clk_in);
    rchk(OFS_CH0_GRC, 32'hA5A);
    wr(OFS_CH0_MODE, 32'h10);
    wr(OFS_CH0_GRC, 32'hFFFF);
    lvl[0] <= 1'b0;
    repeat (6) @(posedge clk_in);
    rchk(OFS_CH0_GRC, 32'hFFFF);
    wr(OFS_CH0_C_CTL, 32'h5);
    #1 chk("ch0 oe blocked", poe[0], 1'b0);
    wr(OFS_CH0_MODE, 32'h0);
    wr(OFS_CH0_C_CTL, 32'h6);
    @(posedge clk_in);
    #1 chk("ch0 init", {poe[0], pout[0]}, 2'h3);
    // cascades: ch1 count into ch0 c, ch0 a match into ch1 a
    wr(OFS_CH0_C_CTL, 32'hC);
    wr(OFS_RUN, 32'h2);
    wr(OFS_RUN, 32'h0);
    rchk(OFS_CH0_GRC, 32'hA5A);
    wr(OFS_CH1_CTL, 32'hC);
    wr(OFS_CNT1, 32'h123);
    wr(OFS_CH0_GRA, 32'hA60);
    wr(OFS_RUN, 32'h1);
    repeat (10) @(posedge clk_in);
    wr(OFS_RUN, 32'h0);
    rchk(OFS_CH1_GRA, 32'h123);
    wr(OFS_CH2_CTL, 32'h5);
    @(posedge clk_in);
    #1 chk("ch2 init", {poe[2], pout[2]}, 2'h3);
    finish_test();
  end
endmodule : timer_pin_io_control_ch0_2_tb_top

bind tpc_top tpc_monitor tpc_monitor_inst (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .ch0_pin_c_out(ch0_pin_c_out), .ch0_pin_c_oe_out(ch0_pin_c_oe_out),
  .ch1_pin_a_oe_out(ch1_pin_a_oe_out), .ch2_pin_a_out(ch2_pin_a_out),
  .ch2_pin_a_oe_out(ch2_pin_a_oe_out));

// ===== tb/tpc_monitor.sv
// checker for the timer pin i/o control top, bound onto tpc_top
// assumes ce_in is held high and no counter runs during control writes
`timescale 1ns/1ns
module tpc_monitor
  import tpc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic [DATA_W-1:0] rdata_out,
  input  wire logic              ch0_pin_c_out,
  input  wire logic              ch0_pin_c_oe_out,
  input  wire logic              ch1_pin_a_oe_out,
  input  wire logic              ch2_pin_a_out,
  input  wire logic              ch2_pin_a_oe_out
);
  // --------------------------------------------------------------------
  // register mirrors
  // --------------------------------------------------------------------
  logic [7:0] ctl0_q;
  logic       buf_q;
  logic [2:0] run_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl0_q <= 8'h00;
      buf_q  <= 1'b0;
      run_q  <= 3'h0;
    end else if (wr_in) begin
      if (addr_in == OFS_CH0_C_CTL) ctl0_q <= wdata_in[7:0];
      if (addr_in == OFS_CH0_MODE) buf_q <= wdata_in[POS_BUF_OP_A];
      if (addr_in == OFS_RUN) run_q <= wdata_in[2:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  property p_rd_idle;
    !$past(rd_in) |-> rdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped;
    rd_in && addr_in == 8'h30 |=> rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_ctl0_read;
    rd_in && addr_in == OFS_CH0_C_CTL |=> rdata_out == {24'h0, ctl0_q};
  endproperty
  a_ctl0_read: assert property (p_ctl0_read) else $error("ctl0 readback");
  property p_c0_cmp;
    wr_in && addr_in == OFS_CH0_C_CTL && !wdata_in[POS_SEL_MODE]
      && !buf_q && !run_q[0]
    |=> ##1 (ch0_pin_c_oe_out == ($past(wdata_in[1:0], 2) != ACT_OFF))
      && ($past(wdata_in[1:0], 2) == ACT_OFF
          || ch0_pin_c_out == $past(wdata_in[POS_SEL_INIT], 2));
  endproperty
  a_c0_cmp: assert property (p_c0_cmp)
    else $error("ch0 compare initial level");
  property p_c0_block;
    buf_q && $past(buf_q) |-> !ch0_pin_c_oe_out;
  endproperty
  a_c0_block: assert property (p_c0_block)
    else $error("ch0 c driven while buffered");
  property p_c1_cap;
    wr_in && addr_in == OFS_CH1_CTL && wdata_in[POS_SEL_MODE]
    |=> ##1 !ch1_pin_a_oe_out [*2];
  endproperty
  a_c1_cap: assert property (p_c1_cap)
    else $error("ch1 driven in capture");
  property p_c2_cmp;
    wr_in && addr_in == OFS_CH2_CTL && !wdata_in[POS_SEL_MODE]
      && wdata_in[1:0] != ACT_OFF && !run_q[2]
    |=> ##1 ch2_pin_a_oe_out
      && ch2_pin_a_out == $past(wdata_in[POS_SEL_INIT], 2);
  endproperty
  a_c2_cmp: assert property (p_c2_cmp)
    else $error("ch2 compare initial level");
  property p_c0_hold;
    !run_q[0] && !$past(run_q[0]) && !$past(wr_in) && !$past(wr_in, 2)
    |-> $stable(ch0_pin_c_out);
  endproperty
  a_c0_hold: assert property (p_c0_hold)
    else $error("ch0 pin moved without match");
  c_cap: cover property (wr_in && addr_in == OFS_CH2_CTL && wdata_in[3]);
  c_blk: cover property (buf_q && wr_in && addr_in == OFS_CH0_C_CTL);
  c_cmp: cover property ($changed(ch2_pin_a_out));
endmodule : tpc_monitor

// ===== tb/tpc_pin_model.sv
// far-side model of the three timer pins
// assumes the bench sets the level each pin takes when released
`timescale 1ns/1ns
module tpc_pin_model (
  input  wire logic [2:0] lvl_in,
  input  wire logic [2:0] out_in,
  input  wire logic [2:0] oe_in,
  output logic      [2:0] pin_out
);
  // device drive wins over the far side
  assign pin_out = (oe_in & out_in) | (~oe_in & lvl_in);
endmodule : tpc_pin_model
